// ---- design/skid_buffer.sv ----
// Purpose : Two-entry buffer with valid/ready on both sides.
// Assumes : Single clock, synchronous active-high reset.
// Notes   : Full at two words; ready drops so the source must stall.
`timescale 1ns/10ps
module skid_buffer (
  input  wire logic                                core_clk,
  input  wire logic                                sys_rst,
  input  wire logic                                in_valid,
  output logic                                     in_ready,
  input  wire logic [strobe_fifo_pkg::DATA_W-1:0]  in_data,
  output logic                                     out_valid,
  input  wire logic                                out_ready,
  output logic      [strobe_fifo_pkg::DATA_W-1:0]  out_data,
  output logic      [1:0]                          count
);

  logic [strobe_fifo_pkg::DATA_W-1:0] slot [strobe_fifo_pkg::SKID_N];
  logic                               push;
  logic                               pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = slot[0];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // ----------------------------------------------------------------
  // Occupancy
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count <= 2'h0;
    end else if (push && !pop) begin
      count <= count + 2'h1;
    end else if (pop && !push) begin
      count <= count - 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Storage: head shifts down on pop, new word lands behind the tail
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      slot[0] <= strobe_fifo_pkg::DATA_RST;
      slot[1] <= strobe_fifo_pkg::DATA_RST;
    end else begin
      if (pop) begin
        slot[0] <= (push && count == 2'h1) ? in_data : slot[1];
      end else if (push && count == 2'h0) begin
        slot[0] <= in_data;
      end
      if (push && ((count == 2'h1 && !pop) || (count == 2'h2))) begin
        slot[1] <= in_data;
      end
    end
  end

endmodule

// ---- design/strobe_fifo_bridge.sv ----
// Purpose : Host strobe glue plus the synchronous FIFO it drives, in either timing mode.
// Assumes : Strobes, chip enable and write data are synchronous to core_clk.
// Notes   : FIFO clock edges are found by sampling the glue clocks; flags move only on them.
`timescale 1ns/10ps

// Overview of operation
// - Read clock follows read strobe; write clock ungated
// - Write enable is chip enable OR inverted OE
// - Read and output enable are chip enable OR OE
// - Standard mode inverts read clock, write unchanged
// - Single-direction space may skip glue entirely
// - Fall-through FIFO accepts depth plus one writes
// - Input ready drops only when completely occupied
// - Output ready holds until last word read
// - OE shows buffered word; edge loads next
// - Writes latched with zero cycles latency
// - Standard FIFO reports full after depth writes
// - Standard read starts at enabled clock edge
// - Fall-through wiring: first standard read invalid
// - Other-space accesses still pulse FIFO clocks
// - Flags update only on their own clock
module strobe_fifo_bridge (
  input  wire logic                                core_clk,
  input  wire logic                                sys_rst,
  input  wire logic                                chip_enable_space_n,
  input  wire logic                                async_read_strobe_n,
  input  wire logic                                async_write_strobe_n,
  input  wire logic                                async_output_enable_n,
  input  wire logic                                first_word_fall_through,
  input  wire logic [strobe_fifo_pkg::DATA_W-1:0]  wr_data,
  output logic                                     fifo_read_clk,
  output logic                                     fifo_write_clk,
  output logic                                     fifo_write_en_n,
  output logic                                     fifo_read_en_n,
  output logic                                     fifo_output_en_n,
  output logic      [strobe_fifo_pkg::DATA_W-1:0]  rd_data,
  output logic                                     rd_data_oe,
  output logic                                     input_ready_flag,
  output logic                                     full_flag,
  output logic                                     output_ready_flag,
  output logic                                     empty_flag_n
);

  // ----------------------------------------------------------------
  // Glue (combinational by design; a register would skew the FIFO clocks)
  // ----------------------------------------------------------------
  strobe_glue u_glue (
    .chip_enable_space_n     (chip_enable_space_n),
    .async_read_strobe_n     (async_read_strobe_n),
    .async_write_strobe_n    (async_write_strobe_n),
    .async_output_enable_n   (async_output_enable_n),
    .first_word_fall_through (first_word_fall_through),
    .fifo_read_clk           (fifo_read_clk),
    .fifo_write_clk          (fifo_write_clk),
    .fifo_write_en_n         (fifo_write_en_n),
    .fifo_read_en_n          (fifo_read_en_n),
    .fifo_output_en_n        (fifo_output_en_n)
  );

  // ----------------------------------------------------------------
  // FIFO clock edge detection
  // ----------------------------------------------------------------
  logic rclk_prev;
  logic wclk_prev;
  logic rd_edge;
  logic wr_edge;

  // Reset to the idle strobe level so no false edge follows release
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rclk_prev <= strobe_fifo_pkg::STROBE_IDLE;
      wclk_prev <= strobe_fifo_pkg::STROBE_IDLE;
    end else begin
      rclk_prev <= fifo_read_clk;
      wclk_prev <= fifo_write_clk;
    end
  end

  assign rd_edge = fifo_read_clk & ~rclk_prev;
  assign wr_edge = fifo_write_clk & ~wclk_prev;

  // ----------------------------------------------------------------
  // Occupancy and write acceptance
  // ----------------------------------------------------------------
  logic [strobe_fifo_pkg::LEVEL_W-1:0] level;
  logic [strobe_fifo_pkg::LEVEL_W-1:0] capacity;
  logic                                write_take;
  logic                                rd_pop;
  logic                                skid_in_ready;
  logic                                skid_out_valid;
  logic [strobe_fifo_pkg::DATA_W-1:0]  skid_out_data;
  logic [1:0]                          skid_count;
  logic [strobe_fifo_pkg::LEVEL_W-1:0] mem_cnt;
  logic                                mem_push;
  logic                                mem_pop;

  // The output buffer counts as storage only with fall-through timing
  assign capacity = first_word_fall_through ? strobe_fifo_pkg::CAP_FIRST_WORD_FALL_THROUGH
                                            : strobe_fifo_pkg::CAP_STD;

  // Word is taken on the very write clock edge, no extra wait
  assign write_take = wr_edge & ~fifo_write_en_n & (level < capacity)
                      & skid_in_ready;

  // Two-entry buffer absorbs a word while the array is full
  skid_buffer u_skid (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .in_valid  (write_take),
    .in_ready  (skid_in_ready),
    .in_data   (wr_data),
    .out_valid (skid_out_valid),
    .out_ready (mem_cnt < strobe_fifo_pkg::CAP_STD),
    .out_data  (skid_out_data),
    .count     (skid_count)
  );

  assign mem_push = skid_out_valid & (mem_cnt < strobe_fifo_pkg::CAP_STD);

  // ----------------------------------------------------------------
  // Memory array
  // ----------------------------------------------------------------
  logic [strobe_fifo_pkg::DATA_W-1:0] mem [strobe_fifo_pkg::DEPTH];
  logic [strobe_fifo_pkg::PTR_W-1:0]  wr_ptr;
  logic [strobe_fifo_pkg::PTR_W-1:0]  rd_ptr;

  always_ff @(posedge core_clk) begin
    if (mem_push) begin
      mem[wr_ptr] <= skid_out_data;
    end
  end

  // Pointers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_ptr <= strobe_fifo_pkg::PTR_RST;
      rd_ptr <= strobe_fifo_pkg::PTR_RST;
    end else begin
      if (mem_push) begin
        wr_ptr <= wr_ptr + strobe_fifo_pkg::PTR_ONE;
      end
      if (mem_pop) begin
        rd_ptr <= rd_ptr + strobe_fifo_pkg::PTR_ONE;
      end
    end
  end

  // Array fill count
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mem_cnt <= strobe_fifo_pkg::LEVEL_RST;
    end else if (mem_push && !mem_pop) begin
      mem_cnt <= mem_cnt + strobe_fifo_pkg::LEVEL_ONE;
    end else if (mem_pop && !mem_push) begin
      mem_cnt <= mem_cnt - strobe_fifo_pkg::LEVEL_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------
  logic                               ob_valid;
  logic [strobe_fifo_pkg::DATA_W-1:0] ob_data;
  logic                               ren_active;
  logic                               first_word_fall_through_fill;

  assign ren_active = ~fifo_read_en_n;
  // Fall-through: a read consumes the buffered word; any edge refills an empty buffer
  assign first_word_fall_through_fill  = first_word_fall_through & (mem_cnt != strobe_fifo_pkg::LEVEL_RST)
                      & (~ob_valid | ren_active);
  // Standard: only an enabled edge starts a read out of the array
  assign mem_pop    = rd_edge & (mem_cnt != strobe_fifo_pkg::LEVEL_RST)
                      & (first_word_fall_through_fill | (~first_word_fall_through & ren_active));
  // A fall-through word leaves storage when read out of the buffer
  assign rd_pop     = rd_edge & ren_active & first_word_fall_through & ob_valid;

  // Loaded one cycle after the edge, covering the access time at this rate
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ob_data  <= strobe_fifo_pkg::DATA_RST;
      ob_valid <= 1'b0;
    end else if (mem_pop) begin
      ob_data  <= mem[rd_ptr];
      ob_valid <= 1'b1;
    end else if (rd_pop) begin
      ob_valid <= 1'b0;
    end else if (rd_edge && !first_word_fall_through && ren_active) begin
      // Standard read of an empty array leaves a stale word in the buffer
      ob_valid <= 1'b0;
    end
  end

  // Total held words: array, skid and, in fall-through mode, the buffer
  assign level = mem_cnt + {3'h0, skid_count}
                 + {4'h0, ob_valid & first_word_fall_through};

  // ----------------------------------------------------------------
  // Data bus towards the host
  // ----------------------------------------------------------------
  // Output enable drives whatever sits in the buffer, even a stale word
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_data    <= strobe_fifo_pkg::DATA_RST;
      rd_data_oe <= 1'b0;
    end else begin
      rd_data    <= ob_data;
      rd_data_oe <= ~fifo_output_en_n;
    end
  end

  // ----------------------------------------------------------------
  // Boundary flags, each moved only by its own FIFO clock
  // ----------------------------------------------------------------
  logic [strobe_fifo_pkg::LEVEL_W-1:0] next_level_w;
  logic [strobe_fifo_pkg::LEVEL_W-1:0] next_mem_r;
  logic                                next_ob_r;

  assign next_level_w = level + {4'h0, write_take};
  assign next_mem_r   = mem_cnt - {4'h0, mem_pop};
  assign next_ob_r    = mem_pop | (ob_valid & ~rd_pop);

  // Write-clock side
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      input_ready_flag <= 1'b1;
      full_flag        <= 1'b0;
    end else if (wr_edge) begin
      input_ready_flag <= (next_level_w < capacity);
      full_flag        <= (next_level_w >= capacity);
    end
  end

  // Read-clock side; a dummy edge still refreshes these
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      output_ready_flag <= 1'b0;
      empty_flag_n      <= 1'b0;
    end else if (rd_edge) begin
      output_ready_flag <= next_ob_r & first_word_fall_through;
      empty_flag_n      <= (next_mem_r != strobe_fifo_pkg::LEVEL_RST);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_write_en_decode: assert property (@(posedge core_clk) disable iff (sys_rst)
    !fifo_write_en_n |-> (!chip_enable_space_n && async_output_enable_n))
    else $error("write enable active outside a chip-enabled write");

  a_read_en_pair: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fifo_read_en_n == fifo_output_en_n)
    and (!fifo_read_en_n |-> (!chip_enable_space_n && !async_output_enable_n)))
    else $error("read or output enable decode wrong");

  // Bus enable lags the output enable by exactly one register stage
  a_bus_enable: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> (rd_data_oe == $past(!fifo_output_en_n)))
    else $error("data bus enable does not follow output enable");

  a_clock_ungated: assert property (@(posedge core_clk) disable iff (sys_rst)
    chip_enable_space_n |-> (fifo_write_clk == async_write_strobe_n))
    else $error("write clock gated by chip enable");

  a_std_read_clock: assert property (@(posedge core_clk) disable iff (sys_rst)
    !first_word_fall_through |-> (fifo_read_clk != async_read_strobe_n))
    else $error("standard mode read clock not inverted");

  a_first_word_fall_through_capacity: assert property (@(posedge core_clk) disable iff (sys_rst)
    ($fell(input_ready_flag) && first_word_fall_through)
    |-> ($past(next_level_w) == strobe_fifo_pkg::CAP_FIRST_WORD_FALL_THROUGH))
    else $error("input ready dropped before depth plus one words");

  a_std_full_depth: assert property (@(posedge core_clk) disable iff (sys_rst)
    ($rose(full_flag) && !first_word_fall_through)
    |-> ($past(next_level_w) == strobe_fifo_pkg::CAP_STD))
    else $error("full flag not at depth words");

  a_write_latency: assert property (@(posedge core_clk) disable iff (sys_rst)
    (write_take && !mem_pop && !rd_pop) |=> (level == $past(level) + 5'h01))
    else $error("accepted write not stored next cycle");

  a_or_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
    (output_ready_flag && !rd_edge) |=> output_ready_flag)
    else $error("output ready fell without a read clock edge");

  a_flag_clocking: assert property (@(posedge core_clk) disable iff (sys_rst)
    ($changed(output_ready_flag) |-> $past(rd_edge))
    and ($changed(input_ready_flag) |-> $past(wr_edge)))
    else $error("flag moved without its clock edge");

  a_buffer_load: assert property (@(posedge core_clk) disable iff (sys_rst)
    mem_pop |=> (ob_valid ##1 (rd_data == $past(ob_data))))
    else $error("read edge did not bring next word to the bus");

  c_first_word_fall_through_fill: cover property (@(posedge core_clk) disable iff (sys_rst)
    first_word_fall_through && $fell(input_ready_flag));
  c_std_full: cover property (@(posedge core_clk) disable iff (sys_rst)
    !first_word_fall_through && $rose(full_flag));
  c_last_read: cover property (@(posedge core_clk) disable iff (sys_rst)
    $fell(output_ready_flag));
  c_skid_full: cover property (@(posedge core_clk) disable iff (sys_rst)
    skid_count == 2'h2);

endmodule

// ---- design/strobe_fifo_pkg.sv ----
// Purpose : Shared constants for the strobe-to-synchronous-FIFO glue.
// Assumes : Host strobes are sampled as synchronous to core_clk.
// Notes   : Depth and width are fixed; cycle counts derive from the 50 MHz rate.
package strobe_fifo_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned DEPTH    = 16;  // Memory cells, output buffer excluded
  localparam int unsigned PTR_W    = 4;
  localparam int unsigned LEVEL_W  = 5;
  localparam int unsigned SKID_N   = 2;

  localparam logic [LEVEL_W-1:0] CAP_STD  = 5'h10;  // Depth D
  localparam logic [LEVEL_W-1:0] CAP_FIRST_WORD_FALL_THROUGH = 5'h11;  // Depth D plus output buffer
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 5'h00;
  localparam logic [PTR_W-1:0]   PTR_RST   = 4'h0;
  localparam logic [PTR_W-1:0]   PTR_ONE   = 4'h1;
  localparam logic [LEVEL_W-1:0] LEVEL_ONE = 5'h01;
  localparam logic [DATA_W-1:0]  DATA_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned T_ACC_NS      = 13;  // Read access time after read clock edge
  // Least time, rounded up, never below one cycle
  localparam int unsigned ACC_CYC =
    ((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Idle levels of strobes after reset
  localparam logic STROBE_IDLE = 1'b1;

endpackage

// ---- design/strobe_glue.sv ----
// Purpose : Pure combinational derivation of FIFO clocks and enables from host strobes.
// Assumes : All strobes and the chip enable are active low.
// Notes   : No register sits in these paths, so strobe edges reach the FIFO at once.
`timescale 1ns/10ps
module strobe_glue (
  input  wire logic chip_enable_space_n,
  input  wire logic async_read_strobe_n,
  input  wire logic async_write_strobe_n,
  input  wire logic async_output_enable_n,
  input  wire logic first_word_fall_through,
  output logic      fifo_read_clk,
  output logic      fifo_write_clk,
  output logic      fifo_write_en_n,
  output logic      fifo_read_en_n,
  output logic      fifo_output_en_n
);

  // ----------------------------------------------------------------
  // Clocks: never gated by chip enable, so other spaces still tick the FIFO
  // ----------------------------------------------------------------
  assign fifo_read_clk  = first_word_fall_through ? async_read_strobe_n
                                                  : ~async_read_strobe_n;
  assign fifo_write_clk = async_write_strobe_n;

  // ----------------------------------------------------------------
  // Enables: write side identical in both modes
  // ----------------------------------------------------------------
  assign fifo_write_en_n  = chip_enable_space_n | ~async_output_enable_n;
  // With oe held high (write-only space) write enable reduces to chip enable alone
  assign fifo_read_en_n   = chip_enable_space_n | async_output_enable_n;
  assign fifo_output_en_n = chip_enable_space_n | async_output_enable_n;

endmodule

// ---- verif/async_strobe_sync_fifo_glue_tb.sv ----
// Purpose : Self-checking bench for the strobe glue and the FIFO behind it.
// Assumes : Host model paces every transfer; mode changes during the glue table and just before each reset.
// Notes   : Reset values and glue table first, then fill and drain in each FIFO mode.
`timescale 1ns/10ps
module async_strobe_sync_fifo_glue_tb;
  logic        core_clk, sys_rst, mode, req, long_strobe, raw_en, done;
  logic        ce_n, rs_n, ws_n, oe_n, rclk, wclk, wen_n, ren_n, oen_n;
  logic        rd_oe, in_rdy, full, out_rdy, empty_n;
  logic [1:0]  op;
  logic [3:0]  raw;
  logic [15:0] wdata, wr_data, rd_data, rdata;
  logic [9:0]  rows [8];
  int          num_errors, checked;

  strobe_host_model host (.core_clk(core_clk), .req(req), .op(op), .wdata(wdata),
    .long_strobe(long_strobe), .raw_en(raw_en), .raw(raw), .rd_data(rd_data),
    .chip_enable_space_n(ce_n), .async_read_strobe_n(rs_n), .async_write_strobe_n(ws_n),
    .async_output_enable_n(oe_n), .wr_data(wr_data), .done(done), .rdata(rdata));

  strobe_fifo_bridge dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .chip_enable_space_n(ce_n), .async_read_strobe_n(rs_n), .async_write_strobe_n(ws_n),
    .async_output_enable_n(oe_n), .first_word_fall_through(mode), .wr_data(wr_data),
    .fifo_read_clk(rclk), .fifo_write_clk(wclk), .fifo_write_en_n(wen_n),
    .fifo_read_en_n(ren_n), .fifo_output_en_n(oen_n), .rd_data(rd_data),
    .rd_data_oe(rd_oe), .input_ready_flag(in_rdy), .full_flag(full),
    .output_ready_flag(out_rdy), .empty_flag_n(empty_n));

  // --------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // --------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Whole run is under 1500 cycles; this margin only catches a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    summarize();
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
  endtask

  // Bounded wait on the host's done pulse, sampled off the edge
  task automatic host_op(input logic [1:0] o, input logic [15:0] d);
    int w;
    @(posedge core_clk);
    op <= o;
    wdata <= d;
    req <= 1'b1;
    @(posedge core_clk);
    req <= 1'b0;
    w = 0;
    do begin
      @(negedge core_clk);
      w++;
    end while (done !== 1'b1 && w < 60);
    if (w >= 60) begin
      num_errors++;
      summarize();
    end
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    // Row: mode, ce, rd, wr, oe | rclk, wclk, wen, ren, oen
    rows = '{10'h24C, 10'h2B3, 10'h327, 10'h3DF, 10'h05C, 10'h0A3, 10'h17F, 10'h187};
    {sys_rst, mode, req, long_strobe, raw_en} = 5'h18;
    {op, raw, wdata, num_errors, checked} = '0;
    raw = 4'hF;
    do_reset();
    check_flag(in_rdy, 1'b1);
    check_flag(full, 1'b0);
    check_flag(out_rdy, 1'b0);
    check_flag(empty_n, 1'b0);
    check_flag(rd_oe, 1'b0);
    $display("test reset values done");
    // Outputs must follow the pins before the next edge
    raw_en <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      mode <= rows[i][9];
      raw <= rows[i][8:5];
      @(posedge core_clk);
      @(negedge core_clk);
      check_word({11'h000, rclk, wclk, wen_n, ren_n, oen_n}, {11'h000, rows[i][4:0]});
    end
    raw <= 4'hF;
    @(posedge core_clk);
    raw_en <= 1'b0;
    mode <= 1'b1;
    do_reset();
    $display("test glue table done");
    // Fall-through: depth plus one words, then one refused
    for (int i = 0; i < 18; i++) begin
      host_op(2'h0, 16'hA000 + 16'(i));
      check_flag(in_rdy, i < 16);
    end
    check_flag(out_rdy, 1'b0);
    host_op(2'h3, 16'h0000);
    check_flag(out_rdy, 1'b1);
    host_op(2'h1, 16'h0000);
    check_word(rdata, 16'hA000);
    check_flag(in_rdy, 1'b0);
    host_op(2'h2, 16'h5555);
    check_flag(in_rdy, 1'b1);
    for (int i = 1; i < 17; i++) begin
      host_op(2'h1, 16'h0000);
      check_word(rdata, 16'hA000 + 16'(i));
      check_flag(out_rdy, i < 16);
    end
    $display("test fall-through fill and drain done");
    // Standard: depth words, full after the last, one refused
    @(posedge core_clk);
    mode <= 1'b0;
    long_strobe <= 1'b1;
    do_reset();
    for (int i = 0; i < 17; i++) begin
      host_op(2'h0, 16'hC000 + 16'(i));
      check_flag(full, i >= 15);
    end
    check_flag(empty_n, 1'b0);
    host_op(2'h3, 16'h0000);
    check_flag(empty_n, 1'b1);
    for (int i = 0; i < 16; i++) begin
      host_op(2'h1, 16'h0000);
      check_word(rdata, 16'hC000 + 16'(i));
      check_flag(empty_n, i < 15);
    end
    check_flag(full, 1'b1);
    host_op(2'h2, 16'h0000);
    check_flag(full, 1'b0);
    $display("test standard fill and drain done");
    summarize();
  end
endmodule

// ---- verif/strobe_host_model.sv ----
// Purpose : Behavioural host that drives the strobes, chip enable and write data.
// Assumes : Commands arrive as a one-cycle req pulse; outputs move on core_clk rising edges, except rdata, latched on a falling edge.
// Notes   : Other-space ops keep this space deselected but still pulse the strobes.
`timescale 1ns/10ps
module strobe_host_model (
  input  wire logic        core_clk,
  input  wire logic        req,
  input  wire logic [1:0]  op,
  input  wire logic [15:0] wdata,
  input  wire logic        long_strobe,
  input  wire logic        raw_en,
  input  wire logic [3:0]  raw,
  input  wire logic [15:0] rd_data,
  output logic             chip_enable_space_n,
  output logic             async_read_strobe_n,
  output logic             async_write_strobe_n,
  output logic             async_output_enable_n,
  output logic [15:0]      wr_data,
  output logic             done,
  output logic [15:0]      rdata
);
  // --------------------------------------------------------------
  // Sequencer: op[0] read, op[1] other chip-enable space
  // --------------------------------------------------------------
  initial begin
    {chip_enable_space_n, async_read_strobe_n} = 2'h3;
    {async_write_strobe_n, async_output_enable_n} = 2'h3;
    wr_data = 16'h0000;
    done = 1'b0;
    rdata = 16'h0000;
    forever begin
      @(posedge core_clk);
      done <= 1'b0;
      if (raw_en) begin
        {chip_enable_space_n, async_read_strobe_n,
         async_write_strobe_n, async_output_enable_n} <= raw;
      end else if (req) begin
        chip_enable_space_n <= op[1];
        if (!op[0]) begin
          // Writes only ever target the write side, never a read space
          async_write_strobe_n <= 1'b0;
          wr_data <= wdata;
          @(posedge core_clk);
          async_write_strobe_n <= 1'b1;  // Rising edge clocks the word in
          @(posedge core_clk);
          wr_data <= ~wdata;  // Released bus must not show the old word
        end else begin
          async_output_enable_n <= 1'b0;
          async_read_strobe_n <= 1'b0;
          // Standard part needs a longer strobe to cover its access time
          repeat (long_strobe ? 4 : 2) @(posedge core_clk);
          @(negedge core_clk);
          rdata <= rd_data;  // Latch at the end of the strobe
          @(posedge core_clk);
          async_read_strobe_n <= 1'b1;
          @(posedge core_clk);
          async_output_enable_n <= 1'b1;
        end
        chip_enable_space_n <= 1'b1;
        @(posedge core_clk);
        done <= 1'b1;
      end
    end
  end
endmodule
